/* pin_arb_pkg.sv */
// Purpose: Shared constants and types for the pin function arbiter.
// Assumes: 32-bit AHB-Lite register bus, word-aligned registers.
// Notes:   Register offsets are byte addresses; index = offset / 4.

package pin_arb_pkg;

  // ****************************************************************
  // Register map (word index = byte offset >> 2)
  // ****************************************************************
  localparam logic [9:0] IDX_DIR = 10'h000;       // pin_direction_regs
  localparam logic [9:0] IDX_ANSEL = 10'h001;     // analog_select_regs
  localparam logic [9:0] IDX_LATCH = 10'h002;     // output data latch
  localparam logic [9:0] IDX_PORT = 10'h003;      // gated input, read only
  localparam logic [9:0] IDX_KEY = 10'h004;       // unlock_key_register
  localparam logic [9:0] IDX_REMAP_CTL = 10'h005; // holds remap_lock_bit
  localparam logic [9:0] IDX_IN_MAP = 10'h040;    // input_map_registers
  localparam logic [9:0] IDX_OUT_MAP = 10'h080;   // output_map_registers

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int LOCK_BIT = 11;
  localparam int MAP_W = 8;
  localparam int KEY_W = 8;
  localparam int ADDR_LO = 2;
  localparam int ADDR_HI = 11;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [7:0] IN_MAP_RST = 8'hFF;  // Routes input to ground
  localparam logic [7:0] OUT_MAP_RST = 8'h00; // Output disconnected
  localparam logic [7:0] OUT_MAP_NONE = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ****************************************************************
  // Unlock sequence states
  // ****************************************************************
  typedef enum logic [2:0] {
    KEY_IDLE = 3'b001,
    KEY_HALF = 3'b010,
    KEY_ARMED = 3'b100
  } key_st_t;

endpackage

/* pin_drive_cell.sv */
// Purpose: Output arbitration for one pin.
// Assumes: Map value 0 means no remappable output, v selects func v-1.
// Notes:   Purely combinational; the top registers the result.

`timescale 1ns/100ps

module pin_drive_cell
  import pin_arb_pkg::*;
#(
  parameter int NUM_OUT_FUNCS = 4
) (
  input wire logic ded_en_i,
  input wire logic ded_val_i,
  input wire logic [MAP_W-1:0] map_sel_i,
  input wire logic [NUM_OUT_FUNCS-1:0] rmp_val_i,
  input wire logic dir_in_i,
  input wire logic lat_i,
  output logic drv_o,
  output logic oe_o
);

  // ****************************************************************
  // Priority: dedicated, then remappable, then general purpose
  // ****************************************************************
  always_comb begin
    drv_o = lat_i;
    oe_o = ~dir_in_i;
    if (ded_en_i) begin
      drv_o = ded_val_i;
      oe_o = 1'b1;
    end else if ((map_sel_i != OUT_MAP_NONE) &&
                 (int'(map_sel_i) <= NUM_OUT_FUNCS)) begin
      drv_o = rmp_val_i[int'(map_sel_i) - 1];
      oe_o = 1'b1;
    end
  end

endmodule

/* input_route_mux.sv */
// Purpose: Selects the pin feeding one remappable input function.
// Assumes: Pin inputs are already gated by the analog selection.
// Notes:   Any index beyond the last pin yields ground.

`timescale 1ns/100ps

module input_route_mux
  import pin_arb_pkg::*;
#(
  parameter int NUM_PINS = 8
) (
  input wire logic [NUM_PINS-1:0] din_i,
  input wire logic [MAP_W-1:0] sel_i,
  output logic val_o
);

  // ****************************************************************
  // Index select with ground for unused codes
  // ****************************************************************
  always_comb begin
    val_o = 1'b0;
    if (int'(sel_i) < NUM_PINS) begin
      val_o = din_i[int'(sel_i)];
    end
  end

endmodule

/* pin_function_arbiter.sv */
// Purpose: Decides which function drives or samples each device pin.
// Assumes: AHB-Lite slave, zero wait states, single word transfers.
// Notes:   All pin outputs are registered, one cycle behind the inputs.
//
// Implementation choices: the register offsets and the AHB-Lite interface to the registers.

`timescale 1ns/100ps

module pin_function_arbiter
  import pin_arb_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int NUM_IN_FUNCS = 4,
  parameter int NUM_OUT_FUNCS = 4
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Pads
  input wire logic [NUM_PINS-1:0] PAD_IN_I,
  output logic [NUM_PINS-1:0] PAD_OUT_O,
  output logic [NUM_PINS-1:0] PAD_OE_O,
  output logic [NUM_PINS-1:0] ANALOG_EN_O,
  // Dedicated functions
  input wire logic [NUM_PINS-1:0] DED_OUT_EN_I,
  input wire logic [NUM_PINS-1:0] DED_OUT_I,
  output logic [NUM_PINS-1:0] DED_IN_O,
  // Remappable functions
  input wire logic [NUM_OUT_FUNCS-1:0] RMP_OUT_I,
  output logic [NUM_IN_FUNCS-1:0] RMP_IN_O
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The read word carries one bit per pin, the input map window is 64
  // words deep and the map code is 8 bits wide, which bounds the counts below
  if (NUM_PINS < 1 || NUM_PINS > 32) begin : g_bad_pins
    $error("NUM_PINS must lie in 1..32");
  end
  if (NUM_IN_FUNCS < 1 || NUM_IN_FUNCS > 64) begin : g_bad_in
    $error("NUM_IN_FUNCS must lie in 1..64");
  end
  if (NUM_OUT_FUNCS < 1 || NUM_OUT_FUNCS > 254) begin : g_bad_out
    $error("NUM_OUT_FUNCS must lie in 1..254");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [NUM_PINS-1:0] dir_in;
    logic [NUM_PINS-1:0] ansel;
    logic [NUM_PINS-1:0] lat;
    logic [NUM_IN_FUNCS-1:0][MAP_W-1:0] in_map;
    logic [NUM_PINS-1:0][MAP_W-1:0] out_map;
    logic lock;
    key_st_t key_st;
    logic wr_pend;
    logic [ADDR_HI-ADDR_LO:0] wr_idx;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_PINS-1:0] ded_in;
    logic [NUM_IN_FUNCS-1:0] rmp_in;
  } state_t;

  localparam int IDX_W = ADDR_HI - ADDR_LO + 1;

  state_t state_ff;
  state_t nxt_state;
  logic [NUM_PINS-1:0] din_gated;
  logic [NUM_PINS-1:0] drv_val;
  logic [NUM_PINS-1:0] drv_oe;
  logic [NUM_IN_FUNCS-1:0] rmp_sel;
  logic [IDX_W-1:0] addr_idx;
  logic [31:0] rd_word;
  logic [IDX_W-1:0] in_off;
  logic [IDX_W-1:0] out_off;
  logic [IDX_W-1:0] win_off;
  logic [IDX_W-1:0] wout_off;
  logic bus_take;

  // ****************************************************************
  // Digital input gating by analog select only
  // ****************************************************************
  // Direction plays no part here, so a driven pin can still be read back
  assign din_gated = PAD_IN_I & ~state_ff.ansel;

  // ****************************************************************
  // Per-pin output arbitration and per-function input routing
  // ****************************************************************
  // One cell per pin; every cell sees all remappable outputs
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    pin_drive_cell #(
      .NUM_OUT_FUNCS(NUM_OUT_FUNCS)
    ) u_cell (
      .ded_en_i(DED_OUT_EN_I[p]),
      .ded_val_i(DED_OUT_I[p]),
      .map_sel_i(state_ff.out_map[p]),
      .rmp_val_i(RMP_OUT_I),
      .dir_in_i(state_ff.dir_in[p]),
      .lat_i(state_ff.lat[p]),
      .drv_o(drv_val[p]),
      .oe_o(drv_oe[p])
    );
  end

  // Each input function picks its pin from the gated levels
  for (genvar f = 0; f < NUM_IN_FUNCS; f++) begin : g_in
    input_route_mux #(
      .NUM_PINS(NUM_PINS)
    ) u_mux (
      .din_i(din_gated),
      .sel_i(state_ff.in_map[f]),
      .val_o(rmp_sel[f])
    );
  end

  // ****************************************************************
  // Address decode helpers
  // ****************************************************************
  // Offsets below a window base wrap to large values; each use pairs
  // them with a base compare so a wrapped offset never selects an entry
  assign addr_idx = HADDR_I[ADDR_HI:ADDR_LO];
  assign in_off = addr_idx - IDX_IN_MAP;
  assign out_off = addr_idx - IDX_OUT_MAP;
  assign win_off = state_ff.wr_idx - IDX_IN_MAP;
  assign wout_off = state_ff.wr_idx - IDX_OUT_MAP;

  // Address phase accepted: selected, bus ready and a new transfer
  assign bus_take = HSEL_I & HREADY_I & (HTRANS_I == HTRANS_NONSEQ);

  // Read mux, sampled in the address phase so that the data phase
  // needs no wait state; the word then stands until the next read
  always_comb begin
    rd_word = WORD_ZERO;
    if (addr_idx == IDX_DIR) begin
      rd_word[NUM_PINS-1:0] = state_ff.dir_in;
    end else if (addr_idx == IDX_ANSEL) begin
      rd_word[NUM_PINS-1:0] = state_ff.ansel;
    end else if (addr_idx == IDX_LATCH) begin
      rd_word[NUM_PINS-1:0] = state_ff.lat;
    end else if (addr_idx == IDX_PORT) begin
      rd_word[NUM_PINS-1:0] = state_ff.ded_in;
    end else if (addr_idx == IDX_REMAP_CTL) begin
      rd_word[LOCK_BIT] = state_ff.lock;
    end else if (addr_idx >= IDX_IN_MAP &&
                 int'(in_off) < NUM_IN_FUNCS) begin
      rd_word[MAP_W-1:0] = state_ff.in_map[int'(in_off)];
    end else if (addr_idx >= IDX_OUT_MAP &&
                 int'(out_off) < NUM_PINS) begin
      rd_word[MAP_W-1:0] = state_ff.out_map[int'(out_off)];
    end
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    nxt_state.ready = 1'b1;
    // No transfer is ever refused, so every answer is OKAY
    nxt_state.resp = 1'b0;

    // Data phase of a write: commit HWDATA
    if (state_ff.wr_pend) begin
      // Any write other than the expected next step drops the sequence
      nxt_state.key_st = KEY_IDLE;
      if (state_ff.wr_idx == IDX_DIR) begin
        nxt_state.dir_in = HWDATA_I[NUM_PINS-1:0];
      end else if (state_ff.wr_idx == IDX_ANSEL) begin
        nxt_state.ansel = HWDATA_I[NUM_PINS-1:0];
      end else if (state_ff.wr_idx == IDX_LATCH) begin
        nxt_state.lat = HWDATA_I[NUM_PINS-1:0];
      end else if (state_ff.wr_idx == IDX_KEY) begin
        // Key steps; a first key always restarts the sequence
        case (state_ff.key_st)
          KEY_IDLE, KEY_ARMED: begin
            if (HWDATA_I[KEY_W-1:0] == KEY_FIRST) begin
              nxt_state.key_st = KEY_HALF;
            end
          end
          KEY_HALF: begin
            if (HWDATA_I[KEY_W-1:0] == KEY_FIRST) begin
              nxt_state.key_st = KEY_HALF;
            end else if (HWDATA_I[KEY_W-1:0] == KEY_SECOND) begin
              nxt_state.key_st = KEY_ARMED;
            end
          end
          default: begin
            nxt_state.key_st = KEY_IDLE;
          end
        endcase
      end else if (state_ff.wr_idx == IDX_REMAP_CTL) begin
        // A lock write without the armed key is dropped silently
        if (state_ff.key_st == KEY_ARMED) begin
          nxt_state.lock = HWDATA_I[LOCK_BIT];
        end
      end else if (state_ff.wr_idx >= IDX_IN_MAP &&
                   int'(win_off) < NUM_IN_FUNCS) begin
        if (!state_ff.lock) begin
          nxt_state.in_map[int'(win_off)] = HWDATA_I[MAP_W-1:0];
        end
      end else if (state_ff.wr_idx >= IDX_OUT_MAP &&
                   int'(wout_off) < NUM_PINS) begin
        if (!state_ff.lock) begin
          nxt_state.out_map[int'(wout_off)] = HWDATA_I[MAP_W-1:0];
        end
      end
    end

    // Address phase: note writes, fetch read data
    nxt_state.wr_pend = 1'b0;
    if (bus_take) begin
      if (HWRITE_I) begin
        nxt_state.wr_pend = 1'b1;
        nxt_state.wr_idx = addr_idx;
      end else begin
        nxt_state.rdata = rd_word;
      end
    end

    // Pin outputs, one driver per pin whatever the analog state
    nxt_state.pad_out = drv_val;
    nxt_state.pad_oe = drv_oe;
    // Every input consumer sees the same gated pin level
    nxt_state.ded_in = din_gated;
    nxt_state.rmp_in = rmp_sel;
  end

  // ****************************************************************
  // State register with clock enable
  // ****************************************************************
  // Clock enable low holds the bus and the pins alike, so a master
  // must not start a transfer while it is low
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_ff.dir_in <= '1;
      state_ff.ansel <= '1;
      state_ff.lat <= '0;
      state_ff.in_map <= {NUM_IN_FUNCS{IN_MAP_RST}};
      state_ff.out_map <= {NUM_PINS{OUT_MAP_RST}};
      state_ff.lock <= 1'b0;
      state_ff.key_st <= KEY_IDLE;
      state_ff.wr_pend <= 1'b0;
      state_ff.wr_idx <= '0;
      state_ff.rdata <= WORD_ZERO;
      state_ff.ready <= 1'b1;
      state_ff.resp <= 1'b0;
      state_ff.pad_out <= '0;
      state_ff.pad_oe <= '0;
      state_ff.ded_in <= '0;
      state_ff.rmp_in <= '0;
    end else if (CE_I) begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Outputs straight from the state register
  // ****************************************************************
  // Bus answers come from flops as well, settled right after an edge
  assign HRDATA_O = state_ff.rdata;
  assign HREADYOUT_O = state_ff.ready;
  assign HRESP_O = state_ff.resp; // Always OKAY
  assign PAD_OUT_O = state_ff.pad_out;
  assign PAD_OE_O = state_ff.pad_oe;
  assign ANALOG_EN_O = state_ff.ansel;
  assign DED_IN_O = state_ff.ded_in;
  assign RMP_IN_O = state_ff.rmp_in;

endmodule

/* pin_arb_checker.sv */
// Purpose: Port-level assertions for the pin function arbiter.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every instance of the arbiter.
`timescale 1ns/100ps
module pin_arb_checker
  import pin_arb_pkg::*;
#(
  parameter int NUM_PINS = 8,
  parameter int NUM_IN_FUNCS = 4,
  parameter int NUM_OUT_FUNCS = 4
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_B_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic [NUM_PINS-1:0] PAD_IN_I,
  input wire logic [NUM_PINS-1:0] PAD_OUT_O,
  input wire logic [NUM_PINS-1:0] PAD_OE_O,
  input wire logic [NUM_PINS-1:0] ANALOG_EN_O,
  input wire logic [NUM_PINS-1:0] DED_OUT_EN_I,
  input wire logic [NUM_PINS-1:0] DED_OUT_I,
  input wire logic [NUM_PINS-1:0] DED_IN_O,
  input wire logic [NUM_IN_FUNCS-1:0] RMP_IN_O
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  logic rd_take;
  // Read address phase accepted by the slave
  assign rd_take = CE_I & HSEL_I & HREADY_I & ~HWRITE_I &
                   (HTRANS_I == HTRANS_NONSEQ);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  AST_DED_OE: assert property (CE_I |=>
    ((PAD_OE_O & $past(DED_OUT_EN_I)) == $past(DED_OUT_EN_I)))
    else $error("dedicated output not enabled on pad");
  AST_DED_VAL: assert property (CE_I |=>
    (((PAD_OUT_O ^ $past(DED_OUT_I)) & $past(DED_OUT_EN_I)) == '0))
    else $error("pad not driven by dedicated output");
  AST_IN_GATE: assert property (
    ($past(CE_I) && $stable(ANALOG_EN_O)) |->
    (DED_IN_O == ($past(PAD_IN_I) & ~ANALOG_EN_O)))
    else $error("dedicated input not gated by analog select");
  AST_RMP_GND: assert property (
    ($past(CE_I) && $stable(ANALOG_EN_O) &&
    (($past(PAD_IN_I) & ~ANALOG_EN_O) == '0)) |-> (RMP_IN_O == '0))
    else $error("remappable input high with no live pad");
  AST_OKAY: assert property (HRESP_O == 1'b0)
    else $error("bus response not okay");
  AST_READY: assert property (HREADYOUT_O == 1'b1)
    else $error("bus wait state inserted");
  AST_RESET: assert property ($rose(RST_B_I) |->
    (ANALOG_EN_O == '1 && RMP_IN_O == '0 && DED_IN_O == '0))
    else $error("wrong pin state after reset");
  AST_RDATA_HOLD: assert property (
    !$past(rd_take) |-> $stable(HRDATA_O))
    else $error("read data moved without a read");
  CV_DED: cover property (|DED_OUT_EN_I);
  CV_READ: cover property (rd_take);
  CV_RMP: cover property (RMP_IN_O != '0);
endmodule

bind pin_function_arbiter pin_arb_checker #(
  .NUM_PINS(NUM_PINS),
  .NUM_IN_FUNCS(NUM_IN_FUNCS),
  .NUM_OUT_FUNCS(NUM_OUT_FUNCS)
) u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I),
  .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
  .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
  .HRESP_O(HRESP_O), .PAD_IN_I(PAD_IN_I), .PAD_OUT_O(PAD_OUT_O),
  .PAD_OE_O(PAD_OE_O), .ANALOG_EN_O(ANALOG_EN_O),
  .DED_OUT_EN_I(DED_OUT_EN_I), .DED_OUT_I(DED_OUT_I),
  .DED_IN_O(DED_IN_O), .RMP_IN_O(RMP_IN_O));

/* pin_ext_model.sv */
// Purpose: External circuitry on the pads.
// Assumes: Weak pull-down on every pad.
// Notes:   Reports contention between pad driver and outside source.
`timescale 1ns/100ps
module pin_ext_model #(
  parameter int NUM_PINS = 8
) (
  input wire logic [NUM_PINS-1:0] pad_out_i,
  input wire logic [NUM_PINS-1:0] pad_oe_i,
  input wire logic [NUM_PINS-1:0] ext_en_i,
  input wire logic [NUM_PINS-1:0] ext_val_i,
  output logic [NUM_PINS-1:0] pad_in_o,
  output logic clash_o
);
  // ****************************************************************
  // Pad level
  // ****************************************************************
  // Driven pad wins, else outside source, else pulled low
  assign pad_in_o = (pad_oe_i & pad_out_i) |
                    (~pad_oe_i & ext_en_i & ext_val_i);
  // Both sides driving one pad at once
  assign clash_o = |(pad_oe_i & ext_en_i);
endmodule

/* tb.sv */
// Purpose: Self-checking bench for the pin function arbiter.
// Assumes: Default parameters; clock enable low in one scenario only.
// Notes:   Random pad traffic over one fixed and three random mapping rounds.
`timescale 1ns/100ps
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb import pin_arb_pkg::*;;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic ce = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = WORD_ZERO, hwdata = WORD_ZERO, hrdata, v, t;
  logic [31:0] s = 32'h0000_0023;
  logic [7:0] ded_en = 8'h00, ded_v = 8'h00, ext_en = 8'h00;
  logic [7:0] ext_v = 8'h00, pad_in, pad_out, pad_oe, ana, ded_in;
  logic [7:0] dir, lat, ansel, omap [8], imap [4];
  logic [3:0] rmp = 4'h0, rin;
  logic [15:0] pe;
  logic [11:0] pi;
  logic hready, hresp, clash;
  int mismatches = 0, compares = 0;
  always #12.5 clk = ~clk;
  pin_function_arbiter dut (.CORE_CLK_I(clk), .RST_B_I(rst_b),
    .CE_I(ce), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out),
    .PAD_OE_O(pad_oe), .ANALOG_EN_O(ana), .DED_OUT_EN_I(ded_en),
    .DED_OUT_I(ded_v), .DED_IN_O(ded_in), .RMP_OUT_I(rmp),
    .RMP_IN_O(rin));
  pin_ext_model ext (.pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .ext_en_i(ext_en), .ext_val_i(ext_v), .pad_in_o(pad_in),
    .clash_o(clash));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic test_done();
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic logic [31:0] ad(input logic [9:0] i);
    return {20'h0_0000, i, 2'b00};
  endfunction
  // Bounded wait for the slave's ready
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      test_done();
    end
  endtask
  // One AHB-Lite single transfer
  task automatic bus(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    `CHK(hresp, 1'b0, "resp")
    hsel <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, ad(i), {24'h00_0000, d}, r);
  endtask
  task automatic rd(input logic [9:0] i);
    bus(1'b0, ad(i), WORD_ZERO, v);
  endtask
  // Expected pad enable and drive value
  function automatic logic [15:0] exp_pads();
    logic [7:0] oe, out;
    for (int p = 0; p < 8; p++) begin
      oe[p] = ded_en[p] | (omap[p] >= 8'h01 && omap[p] <= 8'h04);
      out[p] = ded_en[p] ? ded_v[p] :
               oe[p] ? rmp[omap[p][1:0] - 2'd1] : lat[p];
      oe[p] = oe[p] | ~dir[p];
    end
    return {oe, out};
  endfunction
  // Expected remappable and dedicated inputs
  function automatic logic [11:0] exp_in(input logic [15:0] q);
    logic [7:0] g;
    logic [3:0] ri;
    g = ((q[15:8] & q[7:0]) | (~q[15:8] & ext_en & ext_v)) & ~ansel;
    for (int f = 0; f < 4; f++) begin
      ri[f] = (imap[f] < 8'h08) ? g[imap[f][2:0]] : 1'b0;
    end
    return {ri, g};
  endfunction
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(IDX_DIR);
    `CHK(v, 32'h0000_00FF, "dir rst")
    rd(IDX_ANSEL);
    `CHK(v, 32'h0000_00FF, "ansel rst")
    `CHK(ana, 8'hFF, "analog rst")
    rd(IDX_IN_MAP + 10'd3);
    `CHK(v, 32'h0000_00FF, "in map rst")
    rd(IDX_OUT_MAP + 10'd7);
    `CHK(v, WORD_ZERO, "out map rst")
    rd(IDX_REMAP_CTL);
    `CHK(v, WORD_ZERO, "lock rst")
    rd(10'h0C0);
    `CHK(v, WORD_ZERO, "unmapped")
    for (int k = 0; k < 4; k++) begin
      t = rnd();
      dir = t[7:0];
      lat = t[15:8];
      ansel = (k == 0) ? 8'h00 : t[23:16];
      wr(IDX_DIR, dir);
      wr(IDX_LATCH, lat);
      wr(IDX_ANSEL, ansel);
      for (int p = 0; p < 8; p++) begin
        t = rnd();
        omap[p] = (k == 0) ? 8'h01 : 8'(t % 6);
        wr(IDX_OUT_MAP + 10'(p), omap[p]);
      end
      for (int f = 0; f < 4; f++) begin
        t = rnd();
        imap[f] = (k == 0) ? 8'h00 : 8'(t % 10);
        wr(IDX_IN_MAP + 10'(f), imap[f]);
      end
      rd(IDX_IN_MAP + 10'd2);
      `CHK(v, {24'h00_0000, imap[2]}, "in map")
      for (int i = 0; i < 8; i++) begin
        @(posedge clk);
        t = rnd();
        ded_en <= t[7:0] & t[15:8];
        ded_v <= t[15:8];
        rmp <= t[19:16];
        ext_v <= t[31:24];
        @(posedge clk);
        pe = exp_pads();
        t = rnd();
        ext_en <= t[7:0] & ~pe[15:8];
        repeat (3) @(posedge clk);
        #1;
        pi = exp_in(pe);
        `CHK(pad_oe, pe[15:8], "oe")
        `CHK(pad_out, pe[7:0], "drive")
        `CHK(ded_in, pi[7:0], "ded in")
        `CHK(rin, pi[11:8], "rmp in")
        `CHK(ana, ansel, "analog")
        `CHK(clash, 1'b0, "clash")
      end
    end
    // Port register returns the gated pin levels
    rd(IDX_PORT);
    `CHK(v, {24'h00_0000, pi[7:0]}, "port read")
    // Clock enable low freezes the pins, high lets them follow again
    @(posedge clk);
    ce <= 1'b0;
    ded_en <= ~ded_en;
    ded_v <= ~ded_v;
    repeat (3) @(posedge clk);
    #1;
    `CHK(pad_oe, pe[15:8], "frozen oe")
    `CHK(pad_out, pe[7:0], "frozen drive")
    @(posedge clk);
    ce <= 1'b1;
    pe = exp_pads();
    repeat (2) @(posedge clk);
    #1;
    `CHK(pad_oe, pe[15:8], "thawed oe")
    `CHK(pad_out, pe[7:0], "thawed drive")
    wr(IDX_KEY, KEY_FIRST);
    wr(IDX_KEY, KEY_SECOND);
    bus(1'b1, ad(IDX_REMAP_CTL), 32'h0000_0800, t);
    wr(IDX_OUT_MAP, 8'h03);
    rd(IDX_OUT_MAP);
    `CHK(v, {24'h00_0000, omap[0]}, "locked map")
    wr(IDX_KEY, KEY_FIRST);
    wr(IDX_DIR, dir);
    wr(IDX_KEY, KEY_SECOND);
    wr(IDX_REMAP_CTL, 8'h00);
    rd(IDX_REMAP_CTL);
    `CHK(v, 32'h0000_0800, "broken key")
    wr(IDX_KEY, KEY_FIRST);
    wr(IDX_KEY, KEY_SECOND);
    wr(IDX_REMAP_CTL, 8'h00);
    wr(IDX_OUT_MAP, 8'h03);
    rd(IDX_OUT_MAP);
    `CHK(v, 32'h0000_0003, "unlocked map")
    test_done();
  end
endmodule
